//--- rtl/sswt_consts.vh
// Constants of the soft-switching waveform timer.
`ifndef SSWT_CONSTS_VH
`define SSWT_CONSTS_VH
// ****************************************************************
// Timing
// ****************************************************************
`define SSWT_CLK_PERIOD_NS 10
`define SSWT_TICK_NS 10
`define SSWT_TICK_CYC ((`SSWT_TICK_NS + `SSWT_CLK_PERIOD_NS - 1) / `SSWT_CLK_PERIOD_NS)
`define SSWT_TRIP_NS 200
`define SSWT_TRIP_CYC (`SSWT_TRIP_NS / `SSWT_CLK_PERIOD_NS)
`define SSWT_APERTURE_NS 100
`define SSWT_SEQ_STEP_NS 1000
`define SSWT_SEQ_STEP_CYC (`SSWT_SEQ_STEP_NS / `SSWT_CLK_PERIOD_NS)
// ****************************************************************
// Widths and reset values
// ****************************************************************
`define SSWT_CNT_W 28
`define SSWT_EDGE_N 12
`define SSWT_EDGE_AW 4
`define SSWT_PERIOD_RST 28'h0000063
`define SSWT_SEL_W 4
// ****************************************************************
// Edge memory slots
// ****************************************************************
`define SSWT_E_HV_RISE 4'h0
`define SSWT_E_HV_FALL 4'h1
`define SSWT_E_HC_RISE 4'h2
`define SSWT_E_HC_FALL 4'h3
`define SSWT_E_GT_RISE 4'h4
`define SSWT_E_GT_FALL 4'h5
`define SSWT_E_ON_TRIG 4'h6
`define SSWT_E_OFF_TRIG 4'h7
`define SSWT_E_TW_OPEN 4'h8
`define SSWT_E_TW_CLOSE 4'h9
`define SSWT_E_ON_APER 4'hA
`define SSWT_E_OFF_APER 4'hB
`endif

//--- rtl/sswt_edge_mem.v
// Small register memory that holds the programmed edge positions.
`timescale 1ns/1ps
`default_nettype none
module sswt_edge_mem (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire wr_en_in,
  input wire [3:0] wr_addr_in,
  input wire [27:0] wr_data_in,
  output wire [12*28-1:0] edges_out
);
  reg [27:0] mem_reg [0:11];
  integer i;
  genvar g;
  // ****************************************************************
  // Storage
  // ****************************************************************
  // Writes land in one slot; unused slot addresses are ignored.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (i = 0; i < 12; i = i + 1) begin
        mem_reg[i] <= 28'h0000000;
      end
    end else if (wr_en_in && (wr_addr_in < 4'hC)) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end
  // All slots are read in parallel straight from the registers.
  generate
    for (g = 0; g < 12; g = g + 1) begin : g_out
      assign edges_out[g*28 +: 28] = mem_reg[g];
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/sswt_top.v
// Waveform timing generator for the soft-switching test module.
`timescale 1ns/1ps
`default_nettype none
`include "sswt_consts.vh"
module sswt_top (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire cfg_wr_in,
  input wire [3:0] cfg_addr_in,
  input wire [27:0] cfg_data_in,
  input wire [27:0] period_len_in,
  input wire run_in,
  input wire continuous_in,
  input wire [1:0] cont_sel_in,
  input wire halt_req_in,
  input wire [27:0] halt_at_in,
  input wire resume_in,
  input wire trip_clear_in,
  input wire [3:0] trip_enable_in,
  input wire [3:0] fault_in,
  input wire supply_ovc_in,
  input wire supply_ovv_in,
  input wire supply_on_in,
  input wire [3:0] scope_sel_a_in,
  input wire [3:0] scope_sel_b_in,
  input wire [3:0] relay_sel_in,
  input wire relay_en_in,
  output reg high_voltage_ctrl_out,
  output reg high_current_ctrl_out,
  output reg gate_ctrl_out,
  output reg adc_on_trig_out,
  output reg adc_off_trig_out,
  output reg adc_on_aper_out,
  output reg adc_off_aper_out,
  output reg trip_window_out,
  output reg tripped_out,
  output reg [3:0] trip_cause_out,
  output reg halted_out,
  output reg [27:0] period_count_out,
  output reg drain_supply_en_out,
  output reg high_voltage_supply_en_out,
  output reg gate_supply_en_out,
  output reg scope_a_out,
  output reg scope_b_out,
  output reg scope_trig_out,
  output reg [15:0] relay_out
);
  // Sequencer states, one-hot.
  localparam SEQ_OFF = 4'b0001;
  localparam SEQ_GATE = 4'b0010;
  localparam SEQ_HV = 4'b0100;
  localparam SEQ_ALL = 4'b1000;
  // Cycles per supply step; only the low byte reaches the step counter.
  localparam [31:0] SEQ_STEP = `SSWT_SEQ_STEP_CYC;
  wire [12*28-1:0] edges;
  reg [3:0] fault_s1_reg;
  reg [3:0] fault_s2_reg;
  reg [2:0] sup_s1_reg;
  reg [2:0] sup_s2_reg;
  reg [27:0] count_reg;
  reg [3:0] seq_reg;
  reg [7:0] seq_cnt_reg;
  reg [27:0] count_next;
  wire tick;
  wire running;
  wire [3:0] trip_hit;
  wire stim_ok;
  // Returns the stored position of one edge slot.
  function [27:0] edge_at;
    input [12*28-1:0] e;
    input [3:0] idx;
    begin
      edge_at = e[idx*28 +: 28];
    end
  endfunction
  // Level between a rise and a fall edge, allowing wrap across zero.
  function in_window;
    input [27:0] c;
    input [27:0] r;
    input [27:0] f;
    begin
      if (r <= f) begin
        in_window = (c >= r) && (c < f);
      end else begin
        in_window = (c >= r) || (c < f);
      end
    end
  endfunction
  // Selects one of sixteen observed signals.
  function pick;
    input [15:0] v;
    input [3:0] s;
    begin
      pick = v[s];
    end
  endfunction
  // ****************************************************************
  // Edge storage
  // ****************************************************************
  // Edges are written by the host before pulsing starts.
  sswt_edge_mem u_mem (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(cfg_wr_in & ~run_in),
    .wr_addr_in(cfg_addr_in),
    .wr_data_in(cfg_data_in),
    .edges_out(edges)
  );
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Fault and supply pins come from the analog side and pass two flops.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_s1_reg <= 4'h0;
      fault_s2_reg <= 4'h0;
      sup_s1_reg <= 3'h0;
      sup_s2_reg <= 3'h0;
    end else begin
      fault_s1_reg <= fault_in;
      fault_s2_reg <= fault_s1_reg;
      sup_s1_reg <= {supply_on_in, supply_ovv_in, supply_ovc_in};
      sup_s2_reg <= sup_s1_reg;
    end
  end
  // ****************************************************************
  // Period counter
  // ****************************************************************
  // One clock is one 10 ns tick, so every cycle is a tick.
  assign tick = 1'b1;
  assign running = run_in & ~halted_out & ~tripped_out;
  // Counter wraps at the programmed period length.
  always @* begin
    count_next = count_reg;
    if (tick && running) begin
      if (count_reg >= period_len_in) begin
        count_next = 28'h0000000;
      end else begin
        count_next = count_reg + 28'h0000001;
      end
    end
    if (!run_in) begin
      count_next = 28'h0000000;
    end
  end
  // Halt freezes the counter one past the chosen value, and period_count_out at it in pulsed mode while stim_ok is high, until resumed or run_in drops.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= 28'h0000000;
      halted_out <= 1'b0;
    end else begin
      count_reg <= count_next;
      if (resume_in || !run_in) begin
        halted_out <= 1'b0;
      end else if (halt_req_in && running && count_reg == halt_at_in) begin
        halted_out <= 1'b1;
      end
    end
  end
  // ****************************************************************
  // Fault trips
  // ****************************************************************
  // A fault counts only inside the trip window and while enabled.
  assign trip_hit = fault_s2_reg & trip_enable_in & {4{trip_window_out}};
  // Latched trip; a new trip wins over a simultaneous clear.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tripped_out <= 1'b0;
      trip_cause_out <= 4'h0;
    end else if (|trip_hit) begin
      tripped_out <= 1'b1;
      trip_cause_out <= trip_cause_out | trip_hit;
    end else if (trip_clear_in) begin
      tripped_out <= 1'b0;
      trip_cause_out <= 4'h0;
    end
  end
  assign stim_ok = run_in & ~tripped_out & ~(|trip_hit) & (seq_reg == SEQ_ALL);
  // ****************************************************************
  // Waveform outputs
  // ****************************************************************
  // Edges compare with the counter; in pulsed mode halt holds levels unchanged until stim_ok drops.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      high_voltage_ctrl_out <= 1'b0;
      high_current_ctrl_out <= 1'b0;
      gate_ctrl_out <= 1'b0;
      adc_on_trig_out <= 1'b0;
      adc_off_trig_out <= 1'b0;
      adc_on_aper_out <= 1'b0;
      adc_off_aper_out <= 1'b0;
      trip_window_out <= 1'b0;
      period_count_out <= 28'h0000000;
    end else if (!stim_ok) begin
      high_voltage_ctrl_out <= 1'b0;
      high_current_ctrl_out <= 1'b0;
      gate_ctrl_out <= 1'b0;
      adc_on_trig_out <= 1'b0;
      adc_off_trig_out <= 1'b0;
      adc_on_aper_out <= 1'b0;
      adc_off_aper_out <= 1'b0;
      trip_window_out <= run_in & ~tripped_out;
      period_count_out <= count_reg;
    end else if (continuous_in) begin
      high_voltage_ctrl_out <= (cont_sel_in == 2'h0);
      high_current_ctrl_out <= (cont_sel_in == 2'h1);
      gate_ctrl_out <= (cont_sel_in == 2'h1);
      adc_on_trig_out <= 1'b0;
      adc_off_trig_out <= 1'b0;
      adc_on_aper_out <= 1'b0;
      adc_off_aper_out <= 1'b0;
      trip_window_out <= 1'b1;
      period_count_out <= count_reg;
    end else if (!halted_out) begin
      high_voltage_ctrl_out <= in_window(count_reg, edge_at(edges, `SSWT_E_HV_RISE),
        edge_at(edges, `SSWT_E_HV_FALL));
      // High current yields to high voltage so both never overlap.
      high_current_ctrl_out <= in_window(count_reg, edge_at(edges, `SSWT_E_HC_RISE),
        edge_at(edges, `SSWT_E_HC_FALL)) & ~in_window(count_reg,
        edge_at(edges, `SSWT_E_HV_RISE), edge_at(edges, `SSWT_E_HV_FALL));
      gate_ctrl_out <= in_window(count_reg, edge_at(edges, `SSWT_E_GT_RISE),
        edge_at(edges, `SSWT_E_GT_FALL));
      adc_on_trig_out <= (count_reg == edge_at(edges, `SSWT_E_ON_TRIG));
      adc_off_trig_out <= (count_reg == edge_at(edges, `SSWT_E_OFF_TRIG));
      adc_on_aper_out <= in_window(count_reg, edge_at(edges, `SSWT_E_ON_APER),
        edge_at(edges, `SSWT_E_ON_TRIG));
      adc_off_aper_out <= in_window(count_reg, edge_at(edges, `SSWT_E_OFF_APER),
        edge_at(edges, `SSWT_E_OFF_TRIG));
      trip_window_out <= in_window(count_reg, edge_at(edges, `SSWT_E_TW_OPEN),
        edge_at(edges, `SSWT_E_TW_CLOSE));
      period_count_out <= count_reg;
    end
  end
  // ****************************************************************
  // Supply sequencing
  // ****************************************************************
  // Gate supply first, then high voltage, then drain; faults drop all.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_reg <= SEQ_OFF;
      seq_cnt_reg <= 8'h00;
    end else if (sup_s2_reg[0] || sup_s2_reg[1] || tripped_out || !sup_s2_reg[2]) begin
      seq_reg <= SEQ_OFF;
      seq_cnt_reg <= 8'h00;
    end else if (seq_cnt_reg != 8'h00) begin
      seq_cnt_reg <= seq_cnt_reg - 8'h01;
    end else begin
      seq_cnt_reg <= SEQ_STEP[7:0];
      case (seq_reg)
        SEQ_OFF: seq_reg <= SEQ_GATE;
        SEQ_GATE: seq_reg <= SEQ_HV;
        SEQ_HV: seq_reg <= SEQ_ALL;
        SEQ_ALL: seq_reg <= SEQ_ALL;
        default: seq_reg <= SEQ_OFF;
      endcase
    end
  end
  // Supply enables follow the sequencer state.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_supply_en_out <= 1'b0;
      high_voltage_supply_en_out <= 1'b0;
      drain_supply_en_out <= 1'b0;
    end else begin
      gate_supply_en_out <= (seq_reg != SEQ_OFF);
      high_voltage_supply_en_out <= (seq_reg == SEQ_HV) || (seq_reg == SEQ_ALL);
      drain_supply_en_out <= (seq_reg == SEQ_ALL);
    end
  end
  // ****************************************************************
  // Scope mux and relays
  // ****************************************************************
  // Two independently chosen signals plus a period-start trigger.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scope_a_out <= 1'b0;
      scope_b_out <= 1'b0;
      scope_trig_out <= 1'b0;
      relay_out <= 16'h0000;
    end else begin
      scope_a_out <= pick({6'h00, halted_out, tripped_out, trip_window_out, adc_off_aper_out,
        adc_on_aper_out, adc_off_trig_out, adc_on_trig_out, gate_ctrl_out,
        high_current_ctrl_out, high_voltage_ctrl_out}, scope_sel_a_in);
      scope_b_out <= pick({6'h00, halted_out, tripped_out, trip_window_out, adc_off_aper_out,
        adc_on_aper_out, adc_off_trig_out, adc_on_trig_out, gate_ctrl_out,
        high_current_ctrl_out, high_voltage_ctrl_out}, scope_sel_b_in);
      scope_trig_out <= running & (count_reg == 28'h0000000);
      relay_out <= relay_en_in ? (16'h0001 << relay_sel_in) : 16'h0000;
    end
  end
endmodule
`default_nettype wire

//--- bench/sswt_checker.sv
// Checker of the waveform timer port behaviour, bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module sswt_checker (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [27:0] period_len_in,
  input wire logic run_in,
  input wire logic halt_req_in,
  input wire logic resume_in,
  input wire logic trip_clear_in,
  input wire logic [3:0] trip_enable_in,
  input wire logic [3:0] fault_in,
  input wire logic [3:0] relay_sel_in,
  input wire logic relay_en_in,
  input wire logic high_voltage_ctrl_out,
  input wire logic high_current_ctrl_out,
  input wire logic gate_ctrl_out,
  input wire logic adc_on_trig_out,
  input wire logic trip_window_out,
  input wire logic tripped_out,
  input wire logic halted_out,
  input wire logic [27:0] period_count_out,
  input wire logic drain_supply_en_out,
  input wire logic high_voltage_supply_en_out,
  input wire logic gate_supply_en_out,
  input wire logic [15:0] relay_out
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  // All properties sample on the system clock and rest during reset.
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  property p_no_overlap; !(high_voltage_ctrl_out && high_current_ctrl_out); endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("hv and hc high together");
  property p_trip_kill; tripped_out |-> !(high_voltage_ctrl_out || high_current_ctrl_out ||
    gate_ctrl_out); endproperty
  a_trip_kill: assert property (p_trip_kill) else $error("stimulus while tripped");
  property p_trip_fast; ((|(fault_in & trip_enable_in)) && trip_window_out && !tripped_out)[*3]
    |=> tripped_out; endproperty
  a_trip_fast: assert property (p_trip_fast) else $error("trip too slow");
  property p_trip_sticky; tripped_out && !trip_clear_in |=> tripped_out; endproperty
  a_trip_sticky: assert property (p_trip_sticky) else $error("trip lost");
  property p_halt_hold; halted_out && run_in && !resume_in |=> halted_out &&
    (($stable(period_count_out) && $stable(high_voltage_ctrl_out)) || tripped_out); endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt not held");
  property p_wrap; run_in && $past(run_in) && !halt_req_in && !halted_out && !tripped_out &&
    drain_supply_en_out && $stable(period_len_in) && period_count_out == period_len_in
    |=> period_count_out == 28'h0000000; endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap");
  property p_trig_pulse; adc_on_trig_out && !halt_req_in && period_len_in != 28'h0000000
    |=> !adc_on_trig_out; endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
  property p_hv_seq; $rose(high_voltage_supply_en_out) |-> gate_supply_en_out; endproperty
  a_hv_seq: assert property (p_hv_seq) else $error("hv supply before gate");
  property p_drain_seq; $rose(drain_supply_en_out) |-> $past(high_voltage_supply_en_out);
  endproperty
  a_drain_seq: assert property (p_drain_seq) else $error("drain supply early");
  property p_relay; (relay_en_in && $stable(relay_sel_in))[*3] |->
    relay_out == (16'h0001 << relay_sel_in); endproperty
  a_relay: assert property (p_relay) else $error("relay not one-hot");
endmodule
bind sswt_top sswt_checker u_sswt_checker (.clk_sys_in, .rst_n_in, .period_len_in, .run_in,
  .halt_req_in, .resume_in, .trip_clear_in, .trip_enable_in, .fault_in, .relay_sel_in,
  .relay_en_in, .high_voltage_ctrl_out, .high_current_ctrl_out, .gate_ctrl_out,
  .adc_on_trig_out, .trip_window_out, .tripped_out, .halted_out, .period_count_out,
  .drain_supply_en_out, .high_voltage_supply_en_out, .gate_supply_en_out, .relay_out);
`default_nettype wire

//--- bench/sswt_dut_model.sv
// Behavioural model of the device under test, its supplies and converters.
`timescale 1ns/1ps
`default_nettype none
module sswt_dut_model (
  input wire logic clk_sys_in,
  input wire logic hv_in,
  input wire logic hc_in,
  input wire logic on_trig_in,
  input wire logic off_trig_in,
  input wire logic drain_en_in,
  input wire logic [3:0] fail_cmd_in,
  input wire logic ovc_cmd_in,
  output logic [3:0] fault_out,
  output logic ovc_out,
  output logic [1:0] on_snap_out,
  output logic [1:0] off_snap_out
);
  // A failed device keeps its fault sensed; overcurrent needs the drain supply.
  assign fault_out = fail_cmd_in;
  assign ovc_out = ovc_cmd_in & drain_en_in;
  // Each converter keeps the stimulus state seen at its own trigger.
  always @(posedge clk_sys_in) begin
    if (on_trig_in) on_snap_out <= {hv_in, hc_in};
    if (off_trig_in) off_snap_out <= {hv_in, hc_in};
  end
endmodule
`default_nettype wire

//--- bench/sswt_top_tb.sv
// Self-checking testbench of the soft-switching waveform timer.
`timescale 1ns/1ps
`default_nettype none
module sswt_top_tb;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk_sys_in = 1'h0, rst_n_in = 1'h0, cfg_wr_in = 1'h0, run_in = 1'h0, ovc_cmd = 1'h0;
  logic continuous_in = 1'h0, halt_req_in = 1'h0, resume_in = 1'h0, trip_clear_in = 1'h0;
  logic supply_on_in = 1'h0, supply_ovv_in = 1'h0, relay_en_in = 1'h0;
  logic [3:0] cfg_addr_in = 4'h0, trip_enable_in = 4'hF, fail_cmd = 4'h0, relay_sel_in = 4'h0;
  logic [3:0] scope_sel_a_in = 4'h0, scope_sel_b_in = 4'h1;
  logic [1:0] cont_sel_in = 2'h0;
  logic [27:0] cfg_data_in = 28'h0, halt_at_in = 28'h0;
  logic [27:0] period_len_in = 28'h0000063;
  logic [3:0] fault_in, trip_cause_out;
  logic [1:0] on_snap, off_snap;
  logic supply_ovc_in, high_voltage_ctrl_out, high_current_ctrl_out, gate_ctrl_out;
  logic adc_on_trig_out, adc_off_trig_out, adc_on_aper_out, adc_off_aper_out, trip_window_out;
  logic tripped_out, halted_out, drain_supply_en_out, high_voltage_supply_en_out;
  logic gate_supply_en_out, scope_a_out, scope_b_out, scope_trig_out;
  logic [27:0] period_count_out;
  logic [15:0] relay_out;
  int err_count = 0, n_checks = 0;
  // Edge slots 0 to B, in ticks; apertures settle well before triggers.
  logic [27:0] edges [12] = '{28'h2, 28'h28, 28'h32, 28'h50, 28'h2D, 28'h55, 28'h46, 28'h1E,
    28'h0, 28'h5A, 28'h3C, 28'h14};
  // The clock toggles every half period of 5 ns.
  always #5 clk_sys_in = ~clk_sys_in;
  sswt_top u_sswt_top (.clk_sys_in, .rst_n_in, .cfg_wr_in, .cfg_addr_in, .cfg_data_in,
    .period_len_in, .run_in, .continuous_in, .cont_sel_in, .halt_req_in, .halt_at_in,
    .resume_in, .trip_clear_in, .trip_enable_in, .fault_in, .supply_ovc_in, .supply_ovv_in,
    .supply_on_in, .scope_sel_a_in, .scope_sel_b_in, .relay_sel_in, .relay_en_in,
    .high_voltage_ctrl_out, .high_current_ctrl_out, .gate_ctrl_out, .adc_on_trig_out,
    .adc_off_trig_out, .adc_on_aper_out, .adc_off_aper_out, .trip_window_out, .tripped_out,
    .trip_cause_out, .halted_out, .period_count_out, .drain_supply_en_out,
    .high_voltage_supply_en_out, .gate_supply_en_out, .scope_a_out, .scope_b_out,
    .scope_trig_out, .relay_out);
  sswt_dut_model u_sswt_dut_model (.clk_sys_in(clk_sys_in), .hv_in(high_voltage_ctrl_out),
    .hc_in(high_current_ctrl_out), .on_trig_in(adc_on_trig_out), .off_trig_in(adc_off_trig_out),
    .drain_en_in(drain_supply_en_out), .fail_cmd_in(fail_cmd), .ovc_cmd_in(ovc_cmd),
    .fault_out(fault_in), .ovc_out(supply_ovc_in), .on_snap_out(on_snap), .off_snap_out(off_snap));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic report_and_stop;
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [27:0] seen, input logic [27:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic need(input logic ok);
    if (ok !== 1'h1) begin
      err_count++;
      $display("[FAIL] wait expected 1 seen 0");
      report_and_stop;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [27:0] d);
    cfg_addr_in = a;
    cfg_data_in = d;
    cfg_wr_in = 1'h1;
    cyc(1);
    cfg_wr_in = 1'h0;
    cyc(1);
  endtask
  function automatic logic win(input logic [27:0] pc, input int r, input int f);
    return pc >= r && pc < f;
  endfunction
  task automatic power_up;
    int i;
    supply_on_in = 1'h1;
    for (i = 0; i < 500 && drain_supply_en_out !== 1'h1; i++) cyc(1);
    need(drain_supply_en_out);
    chk("gate_sup", gate_supply_en_out & high_voltage_supply_en_out, 1);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_pulse;
    int i;
    logic [27:0] pc;
    run_in = 1'h1;
    wr(4'h0, 28'h0000063);
    cyc(3);
    for (i = 0; i < 250; i++) begin
      pc = period_count_out;
      chk("hv", high_voltage_ctrl_out, win(pc, 2, 40));
      chk("hc", high_current_ctrl_out, win(pc, 50, 80));
      chk("gate", gate_ctrl_out, win(pc, 45, 85));
      chk("on_trig", adc_on_trig_out, pc == 70);
      chk("off_trig", adc_off_trig_out, pc == 30);
      if (pc != 70) chk("on_aper", adc_on_aper_out, win(pc, 60, 70));
      if (pc != 30) chk("off_aper", adc_off_aper_out, win(pc, 20, 30));
      chk("window", trip_window_out, win(pc, 0, 90));
      chk("scope_trig", scope_trig_out, pc == 0);
      chk("count", pc <= 99, 1);
      cyc(1);
    end
    chk("on_snap", on_snap, 2'h1);
    chk("off_snap", off_snap, 2'h2);
  endtask
  task automatic t_halt;
    int i;
    halt_at_in = 28'h0000041;
    halt_req_in = 1'h1;
    for (i = 0; i < 300 && halted_out !== 1'h1; i++) cyc(1);
    need(halted_out);
    chk("halt_at", period_count_out, 28'h0000041);
    halt_req_in = 1'h0;
    cyc(20);
    chk("frozen", period_count_out, 28'h0000041);
    chk("frozen_hc", high_current_ctrl_out, 1);
    resume_in = 1'h1;
    cyc(1);
    resume_in = 1'h0;
    cyc(3);
    chk("resumed", halted_out, 0);
    chk("moving", period_count_out > 28'h0000041, 1);
  endtask
  task automatic t_trip;
    int i;
    scope_sel_a_in = 4'h8;
    trip_enable_in = 4'hB;
    fail_cmd = 4'h4;
    cyc(30);
    chk("masked", tripped_out, 0);
    trip_enable_in = 4'hF;
    for (i = 0; i < 120 && tripped_out !== 1'h1; i++) cyc(1);
    need(tripped_out);
    chk("cause", trip_cause_out, 4'h4);
    fail_cmd = 4'h0;
    cyc(30);
    chk("latched", tripped_out, 1);
    chk("scope_trip", scope_a_out, 1);
    chk("stim_off", high_voltage_ctrl_out | high_current_ctrl_out | gate_ctrl_out, 0);
    chk("sup_off", drain_supply_en_out, 0);
    trip_clear_in = 1'h1;
    cyc(1);
    trip_clear_in = 1'h0;
    cyc(2);
    chk("cleared", tripped_out, 0);
    scope_sel_a_in = 4'h0;
  endtask
  task automatic t_cont;
    int s;
    supply_on_in = 1'h0;
    cyc(5);
    power_up;
    continuous_in = 1'h1;
    for (s = 0; s < 4; s++) begin
      cont_sel_in = s[1:0];
      cyc(6);
      chk("c_hv", high_voltage_ctrl_out, s == 0);
      chk("c_hc", high_current_ctrl_out & gate_ctrl_out, s == 1);
      chk("scope_a", scope_a_out, s == 0);
      chk("scope_b", scope_b_out, s == 1);
    end
    ovc_cmd = 1'h1;
    for (s = 0; s < 20 && drain_supply_en_out === 1'h1; s++) cyc(1);
    chk("ovc_off", drain_supply_en_out | high_voltage_supply_en_out, 0);
    ovc_cmd = 1'h0;
    power_up;
    supply_ovv_in = 1'h1;
    cyc(5);
    chk("ovv_off", gate_supply_en_out, 0);
    supply_ovv_in = 1'h0;
  endtask
  task automatic t_relay;
    int r;
    relay_en_in = 1'h1;
    for (r = 0; r < 16; r++) begin
      relay_sel_in = r[3:0];
      cyc(3);
      chk("relay", relay_out, 16'h0001 << r);
    end
    relay_en_in = 1'h0;
    cyc(3);
    chk("relay_off", relay_out, 0);
  endtask
  // Main sequence: reset, setup, then each scenario in turn.
  initial begin
    cyc(4);
    rst_n_in = 1'h1;
    cyc(1);
    chk("rst", {tripped_out, drain_supply_en_out, high_voltage_ctrl_out, relay_out}, 0);
    for (int k = 0; k < 12; k++) wr(k[3:0], edges[k]);
    power_up;
    t_pulse;
    t_halt;
    t_trip;
    t_cont;
    t_relay;
    report_and_stop;
  end
endmodule
`default_nettype wire
